// >>> hw/byte_ram.sv
// 256 by 8 array with one write port and a registered read port
`timescale 1ns/1ps
module byte_ram (
  input  wire logic                      ref_clk,
  input  wire logic                      arst_n,
  input  wire logic                      wr_en,
  input  wire logic [pot_pkg::MEM_AW-1:0] wr_addr,
  input  wire logic [7:0]                wr_data,
  input  wire logic [pot_pkg::MEM_AW-1:0] rd_addr,
  output logic      [7:0]                rd_data_q
);
  import pot_pkg::*;

  // storage carries no reset, as a real array would not
  logic [7:0] mem_q [MEM_WORDS];

  // write port
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // read data leaves through a register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= mem_q[rd_addr];
    end
  end

endmodule : byte_ram

// >>> hw/pot_eeprom_cmd.sv
// serial command interpreter for three wipers and a paged byte array
`timescale 1ns/1ps
module pot_eeprom_cmd #(
  parameter int unsigned WRITE_CYCLES = pot_pkg::WC_CYCLES
) (
  input  wire logic                       ref_clk,
  input  wire logic                       arst_n,
  input  wire logic                       scl,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe,
  input  wire logic                       write_latch,
  input  wire pot_pkg::lock_cfg_t         lock_cfg,
  output pot_pkg::wiper_set_t             wiper_out,
  output pot_pkg::wiper_set_t             backing_out,
  output logic                            nv_busy,
  input  wire logic [pot_pkg::MEM_AW-1:0] mem_rd_addr,
  output logic      [7:0]                 mem_rd_data
);
  import pot_pkg::*;

  // link-domain state
  link_st_t               state_q;      // command phase
  link_st_t               state_d;      // phase after this byte
  logic [2:0]             cnt_q;        // bits sampled in current byte
  logic                   ack_ph_q;     // ninth clock of a byte
  logic                   ack_q;        // acknowledge decided for this byte
  logic                   ack_d;        // acknowledge decision
  logic [7:0]             shift_q;      // receive shifter
  logic [7:0]             tx_q;         // readback byte
  logic [1:0]             sel_q;        // selected potentiometer
  logic                   wtype_q;      // write type of last instruction
  logic [7:0]             addr_q;       // array word address
  logic [7:0]             pbuf_q [PAGE_BYTES];  // page staging buffer
  logic [PAGE_BYTES-1:0]  pmask_q;      // staged entries
  logic                   mem_ok_q;     // array write fully acknowledged
  logic                   nv_arm_q;     // nonvolatile wiper write pending
  logic [7:0]             wiper_q [3];  // wiper position registers
  logic [7:0]             backing_q [3];// wiper backing stores
  logic                   sda_oe_q;     // open-drain pull enable
  logic                   sda_o_q;      // driven level, always low
  logic                   start_tog_q;  // flips on each start
  logic                   stop_tog_q;   // flips on each stop
  logic                   start_ack_q;  // last start consumed
  logic                   wel_m, wel_s; // write latch synchroniser
  lock_cfg_t              lock_m, lock_s;
  logic                   busy_m, busy_s;

  // reference-domain state
  ref_st_t                rst_q;
  logic                   stop_m, stop_s, stop_p;
  logic                   mok_m, mok_s, nv_m, nv_s;
  logic [PAGE_AW-1:0]     idx_q;
  logic [WC_W-1:0]        wc_q;
  logic                   busy_q;

  // start flips while the clock is high and data falls
  always_ff @(negedge sda_i or negedge arst_n) begin
    if (!arst_n) begin
      start_tog_q <= 1'b0;
    end else if (scl) begin
      start_tog_q <= ~start_tog_q;
    end
  end

  // stop flips while the clock is high and data rises
  always_ff @(posedge sda_i or negedge arst_n) begin
    if (!arst_n) begin
      stop_tog_q <= 1'b0;
    end else if (scl) begin
      stop_tog_q <= ~stop_tog_q;
    end
  end

  // slow inputs into the link domain; lock settings are quasi-static
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      {wel_m, wel_s, busy_m, busy_s} <= 4'h0;
      lock_m <= '0;
      lock_s <= '0;
    end else begin
      {wel_m, wel_s}   <= {write_latch, wel_m};
      {busy_m, busy_s} <= {busy_q, busy_m};
      lock_m <= lock_cfg;
      lock_s <= lock_m;
    end
  end

  // decoding; the start toggle is settled half a clock before it is read
  wire       start_seen = (start_tog_q != start_ack_q);
  wire [7:0] rx_byte    = {shift_q[6:0], sda_i};
  wire       byte_done  = !start_seen && !ack_ph_q && (cnt_q == BIT_LAST)
                          && (state_q != ST_IDLE);
  wire       id_pot     = (rx_byte[7:1] == ID_POT);
  wire       id_mem     = (rx_byte[7:1] == ID_MEM);
  wire       is_rd      = rx_byte[SA_RW_BIT];
  // locked window compare over full byte
  wire       locked     = lock_s.en && (rx_byte >= lock_s.base);
  // writes depend on the latch being set
  wire       pot_wr     = byte_done && (state_q == ST_POTDATA) && wel_s;
  wire       mem_take   = byte_done && (state_q == ST_MDATA) && wel_s;
  // at least one data byte is staged; a bare word address commits nothing
  wire       mem_staged = (pmask_q != '0);

  // identity code with saturation until the table is supplied
  function automatic logic [7:0] clamp_tap(input logic [1:0] s,
                                           input logic [7:0] d);
    logic [7:0] lim;
    lim = (s == 2'h0) ? TAP_MAX0 : (s == 2'h1) ? TAP_MAX1 : TAP_MAX2;
    // in-range codes map one to one
    clamp_tap = (d > lim) ? lim : d;
  endfunction : clamp_tap

  wire [7:0] tap_new = clamp_tap(sel_q, rx_byte);

  // acknowledge decision for the byte just completed
  always_comb begin
    case (state_q)
      ST_ADDR:    ack_d = !busy_s && (id_pot || (id_mem && !is_rd));
      ST_INSTR:   ack_d = (rx_byte[1:0] != SEL_RSVD);
      ST_POTDATA: ack_d = wel_s;
      ST_WADDR:   ack_d = !locked;
      ST_MDATA:   ack_d = wel_s;
      default:    ack_d = 1'b0;
    endcase
  end

  // phase after the byte just completed
  always_comb begin
    case (state_q)
      ST_ADDR: begin
        if (!ack_d)      state_d = ST_IGNORE;
        else if (id_pot) state_d = is_rd ? ST_RDATA : ST_INSTR;
        else             state_d = ST_WADDR;
      end
      ST_INSTR: state_d = ack_d ? ST_POTDATA : ST_IGNORE;
      ST_WADDR: state_d = ack_d ? ST_MDATA : ST_IGNORE;
      ST_MDATA: state_d = ack_d ? ST_MDATA : ST_IGNORE;
      ST_RDATA: state_d = ST_RDATA;
      default:  state_d = ST_IGNORE;
    endcase
  end

  // byte framing: a start restarts the count at the first address bit
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      state_q     <= ST_IDLE;
      cnt_q       <= 3'h0;
      ack_ph_q    <= 1'b0;
      ack_q       <= 1'b0;
      start_ack_q <= 1'b0;
    end else if (start_seen) begin
      start_ack_q <= start_tog_q;
      state_q     <= ST_ADDR;
      cnt_q       <= 3'h1;
      ack_ph_q    <= 1'b0;
      ack_q       <= 1'b0;
    end else if (ack_ph_q) begin
      // ninth clock: a master no-acknowledge ends a read
      ack_ph_q <= 1'b0;
      ack_q    <= 1'b0;
      cnt_q    <= 3'h0;
      if (state_q == ST_RDATA && sda_i) begin
        state_q <= ST_IGNORE;
      end
    end else if (state_q != ST_IDLE) begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == BIT_LAST) begin
        ack_ph_q <= 1'b1;
        ack_q    <= ack_d;
        state_q  <= state_d;
      end
    end
  end

  // receive shifter takes every edge; only the byte edge uses it
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      shift_q <= 8'h00;
    end else begin
      shift_q <= rx_byte;
    end
  end

  // instruction capture
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      sel_q   <= 2'h0;
      wtype_q <= 1'b0;
    end else if (byte_done && state_q == ST_INSTR && ack_d) begin
      sel_q   <= rx_byte[1:0];
      wtype_q <= rx_byte[WT_BIT];
    end
  end

  // readback load; top bits of narrow wipers read as stored zeros
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      tx_q <= 8'h00;
    end else if (byte_done && state_q == ST_ADDR && id_pot && is_rd) begin
      tx_q <= wiper_q[sel_q];
    end
  end

  // wiper and backing per potentiometer; reset models power-up recall
  for (genvar g = 0; g < 3; g++) begin : g_pot
    always_ff @(posedge scl or negedge arst_n) begin
      if (!arst_n) begin
        wiper_q[g]   <= BACKING_INIT;
        backing_q[g] <= BACKING_INIT;
      end else if (pot_wr && sel_q == 2'(g)) begin
        // latched on the last data bit edge
        wiper_q[g] <= tap_new;
        if (wtype_q) begin
          backing_q[g] <= tap_new;
        end
      end
    end
  end

  // array address: full byte load, then wrap within the page
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      addr_q <= 8'h00;
    end else if (byte_done && state_q == ST_WADDR && ack_d) begin
      addr_q <= rx_byte;
    end else if (mem_take) begin
      addr_q[PAGE_AW-1:0] <= addr_q[PAGE_AW-1:0] + PAGE_IDX_ONE;
    end
  end

  // page staging; held until the write cycle copies it
  always_ff @(posedge scl) begin
    if (mem_take) begin
      pbuf_q[addr_q[PAGE_AW-1:0]] <= rx_byte;
    end
  end

  // staged entry marks, cleared by a fresh word address
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      pmask_q <= '0;
    end else if (byte_done && state_q == ST_WADDR) begin
      pmask_q <= '0;
    end else if (mem_take) begin
      pmask_q[addr_q[PAGE_AW-1:0]] <= 1'b1;
    end
  end

  // commit permission: from a data acknowledge through the next rising clock;
  // that clock may be the stop's own, so only the bit after it withdraws it
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      mem_ok_q <= 1'b0;
      nv_arm_q <= 1'b0;
    end else if (start_seen) begin
      mem_ok_q <= 1'b0;
      nv_arm_q <= 1'b0;
    end else begin
      // a bit of a new byte withdraws it
      if (state_q == ST_MDATA) begin
        mem_ok_q <= ack_ph_q ? (ack_q && mem_staged) :
                    (cnt_q == 3'h0) ? mem_ok_q : 1'b0;
      end
      if (pot_wr && wtype_q) begin
        nv_arm_q <= 1'b1;
      end
    end
  end

  wire tx_bit    = tx_q[BIT_LAST - cnt_q];
  wire pull_low  = !busy_s && ((ack_ph_q && ack_q) ||
                   (state_q == ST_RDATA && !ack_ph_q && !tx_bit));

  // data changes only while the clock is low
  always_ff @(negedge scl or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe_q <= 1'b0;
      sda_o_q  <= 1'b0;
    end else begin
      sda_oe_q <= pull_low;
      sda_o_q  <= 1'b0;
    end
  end

  // link events into the reference domain; clock may stop after a stop
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {stop_m, stop_s, stop_p} <= 3'h0;
      {mok_m, mok_s, nv_m, nv_s} <= 4'h0;
    end else begin
      {stop_m, stop_s, stop_p} <= {stop_tog_q, stop_m, stop_s};
      {mok_m, mok_s} <= {mem_ok_q, mok_m};
      {nv_m, nv_s}   <= {nv_arm_q, nv_m};
    end
  end

  wire stop_evt  = (stop_s != stop_p);
  wire copy_last = (idx_q == PAGE_IDX_END);
  wire wait_last = (wc_q == WC_W'(WRITE_CYCLES - 1));
  // staged buffer is static here: the link refuses writes while busy
  wire ram_we    = (rst_q == RS_COPY) && pmask_q[idx_q];

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q  <= RS_IDLE;
      busy_q <= 1'b0;
    end else begin
      case (rst_q)
        RS_IDLE: begin
          if (stop_evt && (mok_s || nv_s)) begin
            rst_q  <= mok_s ? RS_COPY : RS_WAIT;
            busy_q <= 1'b1;
          end
        end
        RS_COPY: if (copy_last) rst_q <= RS_WAIT;
        RS_WAIT: begin
          if (wait_last) begin
            rst_q  <= RS_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: begin
          rst_q  <= RS_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // copy index and cycle timer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_q <= '0;
      wc_q  <= '0;
    end else begin
      idx_q <= (rst_q == RS_COPY) ? idx_q + PAGE_IDX_ONE : '0;
      wc_q  <= (rst_q == RS_WAIT) ? wc_q + WC_W'(1) : '0;
    end
  end

  byte_ram u_ram (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .wr_en     (ram_we),
    .wr_addr   ({addr_q[MEM_AW-1:PAGE_AW], idx_q}),
    .wr_data   (pbuf_q[idx_q]),
    .rd_addr   (mem_rd_addr),
    .rd_data_q (mem_rd_data)
  );

  assign sda_oe      = sda_oe_q;
  assign sda_o       = sda_o_q;
  assign nv_busy     = busy_q;
  assign wiper_out   = '{w2: wiper_q[2], w1: wiper_q[1], w0: wiper_q[0]};
  assign backing_out = '{w2: backing_q[2], w1: backing_q[1],
                         w0: backing_q[0]};

  // link-domain checks
  pot_addr_ack_a: assert property (@(posedge scl) disable iff (!arst_n)
    byte_done && state_q == ST_ADDR && id_pot && !is_rd && !busy_s
    |=> ack_q && state_q == ST_INSTR)
    else $error("pot address not acknowledged");
  sel_reserved_a: assert property (@(posedge scl) disable iff (!arst_n)
    byte_done && state_q == ST_INSTR && rx_byte[1:0] == SEL_RSVD
    |=> !ack_q && state_q == ST_IGNORE)
    else $error("reserved selector acknowledged");
  vol_write_a: assert property (@(posedge scl) disable iff (!arst_n)
    pot_wr && !wtype_q |=> backing_out == $past(backing_out))
    else $error("volatile write changed backing");
  nv_write_a: assert property (@(posedge scl) disable iff (!arst_n)
    pot_wr && wtype_q |=> backing_q[sel_q] == wiper_q[sel_q])
    else $error("nonvolatile write missed backing");
  tap_sat_a: assert property (@(posedge scl) disable iff (!arst_n)
    pot_wr && sel_q == 2'h0 && rx_byte > TAP_MAX0
    |=> wiper_q[0] == TAP_MAX0)
    else $error("tap did not saturate");
  busy_release_a: assert property (@(posedge scl) disable iff (!arst_n)
    busy_s && $past(busy_s) |-> !sda_oe_q)
    else $error("data pulled while busy");
  busy_nack_a: assert property (@(posedge scl) disable iff (!arst_n)
    byte_done && state_q == ST_ADDR && busy_s |=> !ack_q ##1 !sda_oe_q)
    else $error("address acknowledged while busy");
  lock_nack_a: assert property (@(posedge scl) disable iff (!arst_n)
    byte_done && state_q == ST_WADDR && locked |=> !ack_q)
    else $error("locked address acknowledged");
  page_wrap_a: assert property (@(posedge scl) disable iff (!arst_n)
    mem_take |=> addr_q[7:4] == $past(addr_q[7:4]) &&
    addr_q[3:0] == $past(addr_q[3:0]) + PAGE_IDX_ONE)
    else $error("page address did not wrap");

  // reference-domain checks
  commit_start_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rst_q == RS_IDLE && stop_evt && mok_s |=> busy_q [*8])
    else $error("write cycle not started");
  early_stop_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rst_q == RS_IDLE && stop_evt && !mok_s && !nv_s |=> !busy_q)
    else $error("cancelled write started a cycle");

  pot_nv_c: cover property (@(posedge scl) disable iff (!arst_n)
    pot_wr && wtype_q);
  page_roll_c: cover property (@(posedge scl) disable iff (!arst_n)
    mem_take && addr_q[3:0] == PAGE_IDX_END);
  pot_read_c: cover property (@(posedge scl) disable iff (!arst_n)
    state_q == ST_RDATA && ack_ph_q);
  commit_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
    ram_we);

endmodule : pot_eeprom_cmd

// >>> hw/pot_pkg.sv
// shared constants and types for the potentiometer and memory command block
package pot_pkg;

  // slave address identifiers (upper seven bits of the address byte)
  localparam logic [6:0] ID_POT       = 7'h57;
  localparam logic [6:0] ID_MEM       = 7'h50;
  localparam int         SA_RW_BIT    = 0;

  // instruction byte layout
  localparam int         WT_BIT       = 7;
  localparam logic [1:0] SEL_RSVD     = 2'h3;

  // highest tap code per potentiometer; index 1 stands in for the code table
  localparam logic [7:0] TAP_MAX0     = 8'h3F;
  localparam logic [7:0] TAP_MAX1     = 8'h63;
  localparam logic [7:0] TAP_MAX2     = 8'hFF;
  localparam logic [7:0] BACKING_INIT = 8'h00;

  // serial byte framing
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam int         PAGE_AW      = 4;
  localparam int         PAGE_BYTES   = 16;
  localparam int         MEM_AW       = 8;
  localparam int         MEM_WORDS    = 256;
  localparam logic [3:0] PAGE_IDX_END = 4'hF;
  localparam logic [3:0] PAGE_IDX_ONE = 4'h1;

  // nonvolatile write cycle time and its length in reference clocks
  localparam int unsigned T_WC_US     = 5000;
  localparam int unsigned CLK_NS      = 25;
  localparam int unsigned WC_CYCLES   = (T_WC_US * 1000) / CLK_NS;
  localparam int          WC_W        = 18;

  // link-side command states, one-hot except ST_IGNORE, which is all zeros
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_ADDR    = 7'h02,
    ST_INSTR   = 7'h04,
    ST_POTDATA = 7'h08,
    ST_WADDR   = 7'h10,
    ST_MDATA   = 7'h20,
    ST_RDATA   = 7'h40,
    ST_IGNORE  = 7'h00
  } link_st_t;

  // reference-side write cycle states, one-hot
  typedef enum logic [2:0] {
    RS_IDLE = 3'h1,
    RS_COPY = 3'h2,
    RS_WAIT = 3'h4
  } ref_st_t;

  // three wiper values travelling together
  typedef struct packed {
    logic [7:0] w2;
    logic [7:0] w1;
    logic [7:0] w0;
  } wiper_set_t;

  // array protection window: locked from base upward when enabled
  typedef struct packed {
    logic       en;
    logic [7:0] base;
  } lock_cfg_t;

endpackage : pot_pkg

// >>> tb/i2c_master_model.sv
// two-wire bus master model: drives the link clock and open-drain data
`timescale 1ns/1ps
module i2c_master_model (
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  // clock idles high and stands still between frames; 64 ns period
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  // one clock pulse; the wire is sampled in mid-high
  task automatic pulse(output logic s);
    #16 scl = 1'b1;
    #16 s = sda;
    #16 scl = 1'b0;
    #16;
  endtask : pulse
  // start, also used as repeated start from a low clock
  task automatic start();
    sda_m = 1'b1;
    #16 scl = 1'b1;
    #16 sda_m = 1'b0;
    #16 scl = 1'b0;
    #16;
  endtask : start
  // stop; the caller keeps the bus-free time afterwards
  task automatic stop();
    sda_m = 1'b0;
    #16 scl = 1'b1;
    #16 sda_m = 1'b1;
    #32;
  endtask : stop
  // sends n bits msb first, then an ack clock when the byte is whole
  task automatic put_byte(input logic [7:0] b, input int n, output logic ack);
    logic s;
    ack = 1'b0;
    for (int i = 0; i < n; i++) begin
      sda_m = b[7-i];
      pulse(s);
    end
    if (n == 8) begin
      sda_m = 1'b1;
      pulse(s);
      ack = (s === 1'b0);
    end
  endtask : put_byte
  // receives one byte, then answers with ack or nack
  task automatic get_byte(input logic mack, output logic [7:0] b);
    logic s;
    sda_m = 1'b1;
    for (int i = 0; i < 8; i++) begin
      pulse(s);
      b = {b[6:0], s};
    end
    sda_m = ~mack;
    pulse(s);
    sda_m = 1'b1;
  endtask : get_byte
endmodule : i2c_master_model

// >>> tb/pot_eeprom_serial_commands_test.sv
// self-checking bench for the wiper and array serial commands
`timescale 1ns/1ps
module pot_eeprom_serial_commands_test;
  import pot_pkg::*;
  logic       ref_clk, arst_n, write_latch, scl, sda_m, sda_o, sda_oe, nv_busy;
  wire logic  sda;
  lock_cfg_t  lock_cfg;
  wiper_set_t wiper_out, backing_out;
  logic [7:0] mem_rd_addr, mem_rd_data, obs_v, d, mx, x, e, bk[3], img[256];
  logic [7:0] exp_q[$];
  logic       k;
  int         mismatches, tests_run, cyc;
  event       obs_ev;
  // open drain wire with pull-up
  assign sda = (sda_oe ? sda_o : 1'b1) & sda_m;
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  pot_eeprom_cmd #(.WRITE_CYCLES(50)) DUT (.ref_clk(ref_clk), .arst_n(arst_n),
    .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .write_latch(write_latch), .lock_cfg(lock_cfg), .wiper_out(wiper_out),
    .backing_out(backing_out), .nv_busy(nv_busy), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data));
  i2c_master_model M (.scl(scl), .sda_m(sda_m), .sda(sda));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // note the expectation, then hand the observation to the watcher
  task automatic chk(input logic [7:0] got, input logic [7:0] ex);
    exp_q.push_back(ex);
    obs_v = got;
    ->obs_ev;
    #1;
  endtask : chk
  initial forever begin
    @(obs_ev);
    e = exp_q.pop_front();
    tests_run++;
    if (obs_v !== e) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, obs_v, e);
    end
  end
  // hang guard, far above the expected run length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end
  // three-byte frame with expected acks per byte
  task automatic frame(input logic [7:0] a, b, c, input logic [2:0] ea);
    logic [7:0] v[3];
    v = '{a, b, c};
    M.start();
    for (int i = 0; i < 3; i++) begin
      M.put_byte(v[i], 8, k);
      chk({7'h0, k}, {7'h0, ea[2-i]});
    end
    M.stop();
  endtask : frame
  // checks busy shortly after stop, waits it out, keeps bus-free time
  task automatic idle(input logic busy);
    repeat (8) @(negedge ref_clk);
    chk({7'h0, nv_busy}, {7'h0, busy});
    for (int i = 0; i < 2000 && nv_busy !== 1'b0; i++) @(negedge ref_clk);
    #1400;
  endtask : idle
  // array read port, one reference clock of latency
  task automatic mem(input logic [7:0] a);
    @(negedge ref_clk) mem_rd_addr = a;
    repeat (2) @(negedge ref_clk);
    chk(mem_rd_data, img[a]);
  endtask : mem
  initial begin
    void'($urandom(19382));
    arst_n = 1'b0;
    write_latch = 1'b0;
    lock_cfg = '0;
    mem_rd_addr = 8'h00;
    bk = '{8'h00, 8'h00, 8'h00};
    repeat (8) @(negedge ref_clk);
    arst_n = 1'b1;
    write_latch = 1'b1;
    for (int s = 0; s < 3; s++) chk(wiper_out[s*8 +: 8], 8'h00);
    $display("test reset done");
    // every selector, both write types; nonvolatile writes saturate
    for (int s = 0; s < 3; s++) for (int w = 0; w < 2; w++) begin
      mx = (s == 0) ? TAP_MAX0 : (s == 1) ? TAP_MAX1 : TAP_MAX2;
      d = w ? 8'hFF : 8'($urandom);
      frame(8'hAE, {w[0], 5'h0, s[1:0]}, d, 3'b111);
      idle(w[0]);
      x = (d > mx) ? mx : d;
      if (w) bk[s] = x;
      chk(wiper_out[s*8 +: 8], x);
      chk(backing_out[s*8 +: 8], bk[s]);
      M.start();
      M.put_byte(8'hAE, 8, k);
      M.put_byte({~w[0], 5'h0, s[1:0]}, 8, k);
      M.start();
      M.put_byte(8'hAF, 8, k);
      M.get_byte(1'b0, d);
      M.stop();
      #1400;
      chk(d, x);
      chk(backing_out[s*8 +: 8], bk[s]);
    end
    $display("test wipers done");
    frame(8'hAE, 8'h83, 8'h11, 3'b100);
    frame(8'hA4, 8'h00, 8'h00, 3'b000);
    @(negedge ref_clk) write_latch = 1'b0;
    frame(8'hAE, 8'h02, 8'h05, 3'b110);
    @(negedge ref_clk) write_latch = 1'b1;
    chk(wiper_out.w2, x);
    @(negedge ref_clk) lock_cfg = '{en: 1'b1, base: 8'h80};
    frame(8'hA0, 8'h90, 8'h55, 3'b100);
    @(negedge ref_clk) lock_cfg = '0;
    #1400;
    $display("test refusals done");
    // page write of 18 bytes from offset 11 wraps inside the page
    M.start();
    M.put_byte(8'hA0, 8, k);
    M.put_byte(8'h3B, 8, k);
    for (int i = 0; i < 18; i++) begin
      d = 8'($urandom);
      img[{4'h3, 4'(4'hB + i)}] = d;
      M.put_byte(d, 8, k);
      chk({7'h0, k}, 8'h01);
    end
    M.stop();
    repeat (8) @(negedge ref_clk);
    M.start();
    M.put_byte(8'hA0, 8, k);
    M.stop();
    chk({7'h0, k}, 8'h00);
    idle(1'b1);
    for (int i = 0; i < 16; i++) mem(8'h30 + 8'(i));
    d = 8'($urandom);
    img[8'hFF] = d;
    frame(8'hA0, 8'hFF, d, 3'b111);
    idle(1'b1);
    mem(8'hFF);
    $display("test page done");
    // stop inside a data byte cancels the write
    M.start();
    M.put_byte(8'hA0, 8, k);
    M.put_byte(8'h3C, 8, k);
    M.put_byte(~img[8'h3C], 5, k);
    M.stop();
    idle(1'b0);
    mem(8'h3C);
    $display("test early stop done");
    final_report();
  end
endmodule : pot_eeprom_serial_commands_test
